/* common/sfol_params.svh */
// Constants for the supervisor fault and output logic.
`ifndef SFOL_PARAMS_SVH
`define SFOL_PARAMS_SVH
`define SFOL_ADDR_CTRL 4'h0
`define SFOL_ADDR_INCFG 4'h1
`define SFOL_ADDR_POL 4'h2
`define SFOL_ADDR_LOG 4'h3
`define SFOL_ADDR_STATUS 4'h4
`define SFOL_ADDR_KEY 4'h5
`define SFOL_ADDR_ALERT 4'h6
`define SFOL_ADDR_OUTCFG0 4'h8
`define SFOL_FN_MANUAL 3'h1
`define SFOL_FN_TRIM 3'h2
`define SFOL_FN_UVIGN 3'h3
`define SFOL_FN_AUX_POS 3'h4
`define SFOL_FN_AUX_NEG 3'h5
`define SFOL_POL_RESET 12'hAAA
`define SFOL_KEY_RESET 16'h0000
`define SFOL_LOAD_TIME_US 200
`define SFOL_CLK_MHZ 200
`define SFOL_NV_CYCLES 32
`endif

/* common/sfol_pkg.sv */
// Types shared by the supervisor fault and output logic.
package sfol_pkg;
   typedef enum logic [1:0] {
      SFOL_NV_IDLE = 2'b00,
      SFOL_NV_LOAD = 2'b01,
      SFOL_NV_SAVE = 2'b11
   } sfol_nv_t;
   typedef logic [11:0] sfol_fault_t;
endpackage : sfol_pkg

/* core/sfol_top.sv */
// Fault gating, open-drain output mapping, alert, write lock and nonvolatile sequencing.
`timescale 1ns/10ps
`include "sfol_params.svh"
module sfol_top #(
   parameter int NCH = 6,
   parameter int NOUT = 3,
   parameter int DLY_W = 16,
   parameter int NV_CYCLES = `SFOL_NV_CYCLES
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [NCH-1:0] ABOVE_OVER_IN,
   input wire logic [NCH-1:0] ABOVE_UNDER_IN,
   input wire logic [1:0] GENERAL_INPUT_N_IN,
   input wire logic [1:0] AUX_ABOVE_REF_IN,
   input wire logic [NOUT-1:0] GENERAL_IO_N_IN,
   input wire logic ALERT_RESPONSE_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   output logic [NOUT-1:0] GENERAL_IO_N_OUT,
   output logic [NOUT-1:0] GENERAL_IO_N_OE_OUT,
   output logic [NOUT-1:0] PULLUP_EN_OUT,
   output logic NV_BUSY_OUT,
   output sfol_pkg::sfol_fault_t STATUS_OUT
);
   import sfol_pkg::*;
   localparam int LOAD_CYC = `SFOL_LOAD_TIME_US * `SFOL_CLK_MHZ;
   // Three-stage sampling of pin inputs; a change counts once stages two and three agree.
   logic [5:0] s1_q, s2_q, s3_q, flt_q, flt_d;
   logic [5:0] pin_now;
   assign pin_now = {AUX_ABOVE_REF_IN, GENERAL_INPUT_N_IN, GENERAL_IO_N_IN[1:0]};
   logic gio2_s1_q, gio2_s2_q, gio2_s3_q, gio2_f_q, gio2_f_d;
   always_comb begin
      flt_d = flt_q;
      for (int i = 0; i < 6; i++) begin
         if (s2_q[i] == s3_q[i]) flt_d[i] = s2_q[i];
      end
      gio2_f_d = (gio2_s2_q == gio2_s3_q) ? gio2_s2_q : gio2_f_q;
   end
   always_ff @(posedge CLK_IN) begin
      s1_q <= pin_now;
      s2_q <= s1_q;
      s3_q <= s2_q;
      gio2_s1_q <= GENERAL_IO_N_IN[2];
      gio2_s2_q <= gio2_s1_q;
      gio2_s3_q <= gio2_s2_q;
      if (!RST_N_IN) begin
         flt_q <= 6'h3F;
         gio2_f_q <= 1'b1;
      end else begin
         flt_q <= flt_d;
         gio2_f_q <= gio2_f_d;
      end
   end
   logic [1:0] gin_n, aux_above;
   logic [NOUT-1:0] gio_n;
   assign gin_n = flt_q[3:2];
   assign aux_above = flt_q[5:4];
   assign gio_n = {gio2_f_q, flt_q[1:0]};
   // Operating registers.
   logic [5:0] incfg_q, incfg_d;
   logic [1:0] clrlog_q, clrlog_d;
   logic [11:0] pol_q, pol_d;
   logic [15:0] key_q, key_d;
   logic lock_q, lock_d;
   logic [11:0] log_q, log_d;
   logic [NOUT-1:0] alert_sel_q, alert_sel_d, alert_q, alert_d;
   logic [NOUT-1:0] pull_q, pull_d;
   logic [NOUT-1:0][15:0] map_q, map_d;
   logic [NOUT-1:0][DLY_W-1:0] dly_q, dly_d;
   sfol_nv_t nv_q, nv_d;
   logic [15:0] nvcnt_q, nvcnt_d;
   logic [31:0] rd_q, rd_d;
   logic rvalid_q, rvalid_d;
   // Nonvolatile image of the configuration; it is kept through reset and starts from the shipped defaults.
   localparam int IMG_W = 37 + 2 * NOUT + NOUT * (16 + DLY_W);
   localparam logic [IMG_W-1:0] IMG_DEFAULT = {8'h00, `SFOL_POL_RESET, `SFOL_KEY_RESET, {(IMG_W-36){1'b0}}};
   logic [IMG_W-1:0] img_q = IMG_DEFAULT;
   logic [IMG_W-1:0] img_d, cfg_now;
   logic [1:0] manual, trim, uvign, auxf;
   logic [11:0] raw, live;
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         manual[g] = (incfg_q[3*g+:3] == `SFOL_FN_MANUAL) && !gin_n[g];
         trim[g] = (incfg_q[3*g+:3] == `SFOL_FN_TRIM) && !gin_n[g];
         uvign[g] = (incfg_q[3*g+:3] == `SFOL_FN_UVIGN) && !gin_n[g];
         auxf[g] = ((incfg_q[3*g+:3] == `SFOL_FN_AUX_POS) && aux_above[g])
            || ((incfg_q[3*g+:3] == `SFOL_FN_AUX_NEG) && !aux_above[g]);
      end
      for (int c = 0; c < NCH; c++) begin
         // Bit 2c+1 is over, bit 2c is under; polarity one faults above.
         raw[2*c+1] = pol_q[2*c+1] ? ABOVE_OVER_IN[c] : !ABOVE_OVER_IN[c];
         raw[2*c] = pol_q[2*c] ? ABOVE_UNDER_IN[c] : !ABOVE_UNDER_IN[c];
         live[2*c+1] = raw[2*c+1] && !(|trim);
         live[2*c] = raw[2*c] && !(|trim) && !(|uvign);
      end
   end
   assign STATUS_OUT = live;
   // Outputs with delay-on-release.
   logic [NOUT-1:0] src, busy_n;
   logic [NOUT-1:0][DLY_W-1:0] rel_q, rel_d;
   logic [NOUT-1:0] act_q, act_d;
   genvar o;
   generate
      for (o = 0; o < NOUT; o++) begin : g_out
         logic [15:0] srcs;
         assign srcs = {live, manual | auxf, gio_n[(o+1)%NOUT] == 1'b0, gio_n[(o+2)%NOUT] == 1'b0};
         assign src[o] = |(srcs & map_q[o]);
         always_comb begin
            rel_d[o] = rel_q[o];
            act_d[o] = act_q[o];
            if (src[o]) begin
               act_d[o] = 1'b1;
               rel_d[o] = dly_q[o];
            end else if (rel_q[o] != '0) begin
               rel_d[o] = rel_q[o] - 1'b1;
            end else begin
               act_d[o] = 1'b0;
            end
         end
         // Alert outputs drive only while the latched alert stands; other outputs follow their OR term.
         assign busy_n[o] = alert_sel_q[o] ? alert_q[o] : (src[o] | act_q[o]);
      end
   endgenerate
   assign GENERAL_IO_N_OUT = '0;
   assign GENERAL_IO_N_OE_OUT = busy_n;
   assign PULLUP_EN_OUT = pull_q;
   assign NV_BUSY_OUT = (nv_q != SFOL_NV_IDLE);
   // Bus: a write is taken at once; a read waits one cycle so its registered data stand when the wait ends.
   logic acc, wr, rd, wr_ok;
   assign acc = (AVS_READ_IN || AVS_WRITE_IN) && (nv_q == SFOL_NV_IDLE);
   assign AVS_WAITREQUEST_OUT = AVS_READ_IN && !rvalid_q;
   assign cfg_now = {incfg_q, clrlog_q, pol_q, key_q, lock_q, alert_sel_q, pull_q, map_q, dly_q};
   assign wr = acc && AVS_WRITE_IN;
   assign rd = acc && AVS_READ_IN;
   assign wr_ok = wr && !lock_q;
   always_comb begin
      incfg_d = incfg_q;
      clrlog_d = clrlog_q;
      pol_d = pol_q;
      key_d = key_q;
      lock_d = lock_q;
      alert_sel_d = alert_sel_q;
      pull_d = pull_q;
      map_d = map_q;
      dly_d = dly_q;
      nv_d = nv_q;
      nvcnt_d = nvcnt_q;
      rd_d = '0;
      rvalid_d = AVS_READ_IN && !rvalid_q;
      img_d = img_q;
      log_d = log_q | live;
      alert_d = alert_q;
      for (int k = 0; k < NOUT; k++) begin
         if (ALERT_RESPONSE_IN && alert_q[k]) alert_d[k] = 1'b0;
         if (rd && AVS_ADDRESS_IN == `SFOL_ADDR_LOG && !src[k]) alert_d[k] = 1'b0;
         if (src[k]) alert_d[k] = 1'b1;
      end
      if (|(manual & clrlog_q)) log_d = live;
      if (nv_q != SFOL_NV_IDLE) begin
         if (nvcnt_q != 16'h0000) begin
            nvcnt_d = nvcnt_q - 1'b1;
         end else begin
            nv_d = SFOL_NV_IDLE;
            // The copy lands at the end, so a reset in mid-save leaves the old image whole.
            if (nv_q == SFOL_NV_SAVE) begin
               img_d = cfg_now;
            end else begin
               {incfg_d, clrlog_d, pol_d, key_d, lock_d, alert_sel_d, pull_d, map_d, dly_d} = img_q;
            end
         end
      end
      if (wr && lock_q && AVS_ADDRESS_IN == `SFOL_ADDR_KEY && AVS_WRITEDATA_IN[31:16] == key_q) begin
         lock_d = AVS_WRITEDATA_IN[0];
      end
      if (wr_ok) begin
         unique case (AVS_ADDRESS_IN)
            `SFOL_ADDR_CTRL: begin
               lock_d = AVS_WRITEDATA_IN[0];
               if (AVS_WRITEDATA_IN[1]) begin
                  nv_d = SFOL_NV_SAVE;
                  nvcnt_d = 16'(NV_CYCLES);
               end else if (AVS_WRITEDATA_IN[2]) begin
                  nv_d = SFOL_NV_LOAD;
                  nvcnt_d = 16'(NV_CYCLES);
               end
            end
            `SFOL_ADDR_INCFG: begin
               incfg_d = AVS_WRITEDATA_IN[5:0];
               clrlog_d = AVS_WRITEDATA_IN[9:8];
               pull_d = AVS_WRITEDATA_IN[18:16];
               alert_sel_d = AVS_WRITEDATA_IN[26:24];
            end
            `SFOL_ADDR_POL: pol_d = AVS_WRITEDATA_IN[11:0];
            `SFOL_ADDR_LOG: log_d = live;
            `SFOL_ADDR_KEY: key_d = AVS_WRITEDATA_IN[15:0];
            default: begin
               for (int k = 0; k < NOUT; k++) begin
                  if (AVS_ADDRESS_IN == `SFOL_ADDR_OUTCFG0 + 4'(k)) begin
                     map_d[k] = AVS_WRITEDATA_IN[15:0];
                     dly_d[k] = AVS_WRITEDATA_IN[16+:DLY_W];
                  end
               end
            end
         endcase
      end
      if (wr && !lock_q && AVS_ADDRESS_IN == `SFOL_ADDR_LOG) begin
         for (int k = 0; k < NOUT; k++) begin
            if (!src[k]) alert_d[k] = 1'b0;
         end
      end
      if (rd) begin
         unique case (AVS_ADDRESS_IN)
            `SFOL_ADDR_CTRL: rd_d = {31'h0, lock_q};
            `SFOL_ADDR_INCFG: rd_d = {5'h0, alert_sel_q, 5'h0, pull_q, 6'h0, clrlog_q, 2'h0, incfg_q};
            `SFOL_ADDR_POL: rd_d = {20'h0, pol_q};
            `SFOL_ADDR_LOG: rd_d = {20'h0, log_q};
            `SFOL_ADDR_STATUS: rd_d = {20'h0, live};
            `SFOL_ADDR_ALERT: rd_d = {29'h0, alert_q};
            default: begin
               for (int k = 0; k < NOUT; k++) begin
                  if (AVS_ADDRESS_IN == `SFOL_ADDR_OUTCFG0 + 4'(k)) begin
                     rd_d = {16'(dly_q[k]), map_q[k]};
                  end
               end
            end
         endcase
      end
   end
   always_ff @(posedge CLK_IN) begin
      img_q <= img_d;
      if (!RST_N_IN) begin
         incfg_q <= '0;
         clrlog_q <= '0;
         pol_q <= `SFOL_POL_RESET;
         key_q <= `SFOL_KEY_RESET;
         lock_q <= 1'b0;
         log_q <= '0;
         alert_sel_q <= '0;
         alert_q <= '0;
         pull_q <= '0;
         map_q <= '0;
         dly_q <= '0;
         rel_q <= '0;
         act_q <= '0;
         nv_q <= SFOL_NV_LOAD;
         nvcnt_q <= 16'(NV_CYCLES < LOAD_CYC ? NV_CYCLES : LOAD_CYC - 1);
         rd_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         incfg_q <= incfg_d;
         clrlog_q <= clrlog_d;
         pol_q <= pol_d;
         key_q <= key_d;
         lock_q <= lock_d;
         log_q <= log_d;
         alert_sel_q <= alert_sel_d;
         alert_q <= alert_d;
         pull_q <= pull_d;
         map_q <= map_d;
         dly_q <= dly_d;
         rel_q <= rel_d;
         act_q <= act_d;
         nv_q <= nv_d;
         nvcnt_q <= nvcnt_d;
         rd_q <= rd_d;
         rvalid_q <= rvalid_d;
      end
   end
   assign AVS_READDATA_OUT = rd_q;
   property p_lock_blocks;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
         (AVS_WRITE_IN && lock_q && AVS_ADDRESS_IN == `SFOL_ADDR_POL) |=> $stable(pol_q);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("Locked write changed polarity.");
   property p_nv_ignore;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
         (nv_q != SFOL_NV_IDLE && nvcnt_q != 16'h0000 && AVS_WRITE_IN) |=> $stable(incfg_q) && $stable(key_q);
   endproperty
   a_nv_ignore: assert property (p_nv_ignore) else $error("Write taken during NV transaction.");
   property p_assert_now;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
         (src[0] && !alert_sel_q[0]) |-> GENERAL_IO_N_OE_OUT[0] ##1 act_q[0];
   endproperty
   a_assert_now: assert property (p_assert_now) else $error("Output not asserted with source.");
   property p_release;
      @(posedge CLK_IN) disable iff (!RST_N_IN)
         ($fell(src[1]) && !alert_sel_q[1] && dly_q[1] == 16'h0002 && !src[1]) |-> busy_n[1] ##1 busy_n[1];
   endproperty
   a_release: assert property (p_release) else $error("Output released before delay.");
   property p_trim;
      @(posedge CLK_IN) disable iff (!RST_N_IN) (|trim) |-> (live == 12'h000);
   endproperty
   a_trim: assert property (p_trim) else $error("Fault seen while trim test active.");
   property p_uvign;
      @(posedge CLK_IN) disable iff (!RST_N_IN) (|uvign) |-> ((live & 12'h555) == 12'h000);
   endproperty
   a_uvign: assert property (p_uvign) else $error("Under fault seen while ignored.");
   property p_ara;
      @(posedge CLK_IN) disable iff (!RST_N_IN) (ALERT_RESPONSE_IN && !src[2]) |=> !alert_q[2];
   endproperty
   a_ara: assert property (p_ara) else $error("Alert not released by response.");
   property p_boot;
      @(posedge CLK_IN) $rose(RST_N_IN) |-> NV_BUSY_OUT;
   endproperty
   a_boot: assert property (p_boot) else $error("No load after reset.");
endmodule : sfol_top

/* sim/sfol_host.sv */
// Far-side model: open-drain pin wiring and the alert-response host.
`timescale 1ns/10ps
module sfol_host (
   input wire logic CLK_IN,
   input wire logic [2:0] OE_IN,
   input wire logic [2:0] EXT_LOW_IN,
   input wire logic ARA_REQ_IN,
   output logic [2:0] PIN_OUT,
   output logic ARA_OUT
);
   // Board pull-ups hold a released line high, so it never keeps a stale low.
   assign PIN_OUT = ~(OE_IN | EXT_LOW_IN);
   // The answered alert response read is seen by the device as one pulse.
   always_ff @(posedge CLK_IN) begin
      ARA_OUT <= ARA_REQ_IN & ~ARA_OUT;
   end
endmodule : sfol_host

/* sim/tb.sv */
// Self-checking bench for the supervisor fault and output logic.
`timescale 1ns/10ps
module tb;
   import sfol_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] ov = 6'h00;
   logic [5:0] un = 6'h3F;
   logic [1:0] gi = 2'h3;
   logic [1:0] aux = 2'h0;
   logic [2:0] ext = 3'h0;
   logic ara_req = 1'b0;
   logic ara;
   logic [2:0] pin;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdq;
   logic [31:0] rdat;
   logic wrq;
   logic [2:0] io_o;
   logic [2:0] oe;
   logic [2:0] pu;
   logic busy;
   sfol_fault_t stat;
   logic [11:0] pol = 12'hAAA;
   logic [31:0] incfg = 32'h0;
   int fails = 0;
   int n_checks = 0;
   always #2.5 clk = ~clk;
   sfol_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ABOVE_OVER_IN(ov), .ABOVE_UNDER_IN(un),
      .GENERAL_INPUT_N_IN(gi), .AUX_ABOVE_REF_IN(aux), .GENERAL_IO_N_IN(pin), .ALERT_RESPONSE_IN(ara),
      .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
      .AVS_READDATA_OUT(rdq), .AVS_WAITREQUEST_OUT(wrq), .GENERAL_IO_N_OUT(io_o),
      .GENERAL_IO_N_OE_OUT(oe), .PULLUP_EN_OUT(pu), .NV_BUSY_OUT(busy), .STATUS_OUT(stat));
   sfol_host host (.CLK_IN(clk), .OE_IN(oe), .EXT_LOW_IN(ext), .ARA_REQ_IN(ara_req), .PIN_OUT(pin),
      .ARA_OUT(ara));
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Looks happen at the edge, before that edge's own updates land, so they see settled values.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      i = 0;
      do begin
         tick(1);
         i++;
      end while (wrq !== 1'b0 && i < 50);
      if (wrq !== 1'b0) begin
         chk("waitrequest", 0, 1);
         end_of_test();
      end
      rdat = rdq;
      wr <= 1'b0;
      rd <= 1'b0;
      tick(1);
   endtask : bus
   task automatic wnv(input int lim);
      int i;
      i = 0;
      while (busy !== 1'b0) begin
         tick(1);
         i++;
         if (i > lim) begin
            chk("nv_busy", 0, 1);
            end_of_test();
         end
      end
   endtask : wnv
   function automatic logic [11:0] fw();
      logic [11:0] f;
      for (int c = 0; c < 6; c++) begin
         f[2*c+1] = pol[2*c+1] ? ov[c] : ~ov[c];
         f[2*c] = pol[2*c] ? un[c] : ~un[c];
      end
      for (int k = 0; k < 2; k++) begin
         if (!gi[k] && incfg[3*k+:3] == 3'h3) f &= 12'hAAA;
         if (!gi[k] && incfg[3*k+:3] == 3'h2) f = 12'h000;
      end
      return f;
   endfunction : fw
   initial begin
      void'($urandom(32'hEE7F9811));
      tick(20);
      rst_n <= 1'b1;
      tick(1);
      chk("busy_after_reset", 1, busy);
      bus(1, 4'h5, 32'h7);
      bus(0, 4'h2, 32'h0);
      chk("read_during_load", 0, rdat);
      wnv(40000);
      bus(0, 4'h2, 32'h0);
      chk("pol_default", 32'hAAA, rdat);
      repeat (20) begin
         ov <= 6'($urandom());
         un <= 6'($urandom());
         pol = 12'($urandom());
         bus(1, 4'h2, {20'h0, pol});
         tick(8);
         chk("status", fw(), stat);
      end
      pol = 12'hAAA;
      bus(1, 4'h2, {20'h0, pol});
      ov <= 6'h3F;
      un <= 6'h00;
      incfg = 32'h1A;
      bus(1, 4'h1, incfg);
      for (int g = 0; g < 4; g++) begin
         gi <= 2'(g);
         tick(10);
         chk("masked_status", fw(), stat);
      end
      gi <= 2'h3;
      ov <= 6'h00;
      un <= 6'h3F;
      $display("done status and masking");
      bus(1, 4'h8, {16'd20, 16'h0020});
      ov <= 6'h01;
      tick(6);
      chk("oe_assert", 1, oe[0]);
      chk("pin_drive_level", 0, io_o);
      ov <= 6'h00;
      tick(15);
      ov <= 6'h01;
      tick(6);
      ov <= 6'h00;
      tick(15);
      chk("oe_held_by_restart", 1, oe[0]);
      tick(30);
      chk("oe_release", 0, oe[0]);
      $display("done release delay");
      incfg = 32'h0005_0121;
      bus(1, 4'h1, incfg);
      bus(1, 4'h8, 32'h2);
      bus(1, 4'h9, 32'h0002_0004);
      bus(1, 4'hA, 32'h8);
      chk("pullup", 5, pu);
      ext <= 3'b010;
      tick(8);
      chk("io_input_map", 1, oe);
      ext <= 3'b000;
      tick(8);
      gi <= 2'b10;
      tick(10);
      chk("manual_reset_map", 3, oe);
      bus(0, 4'h3, 32'h0);
      chk("log_cleared", 0, rdat);
      gi <= 2'b11;
      for (int f = 4; f < 6; f++) begin
         incfg[5:3] = 3'(f);
         bus(1, 4'h1, incfg);
         for (int a = 0; a < 2; a++) begin
            aux <= {1'(a), 1'b0};
            tick(8);
            chk("aux_output", 1'(a) ^ (f == 5), oe[2]);
         end
      end
      $display("done mapping");
      incfg[26] = 1'b1;
      bus(1, 4'h1, incfg);
      bus(1, 4'hA, 32'h20);
      ov <= 6'h01;
      tick(6);
      ov <= 6'h00;
      tick(8);
      chk("alert_latched", 1, oe[2]);
      ara_req <= 1'b1;
      tick(1);
      ara_req <= 1'b0;
      tick(4);
      chk("alert_after_response", 0, oe[2]);
      ov <= 6'h01;
      tick(6);
      bus(0, 4'h3, 32'h0);
      tick(4);
      chk("alert_kept", 1, oe[2]);
      ov <= 6'h00;
      tick(6);
      bus(0, 4'h3, 32'h0);
      tick(4);
      chk("alert_log_read", 0, oe[2]);
      $display("done alert");
      bus(1, 4'h5, 32'h1234);
      bus(1, 4'h0, 32'h1);
      bus(1, 4'h2, 32'h555);
      bus(0, 4'h2, 32'h0);
      chk("pol_locked", pol, rdat);
      bus(1, 4'h5, 32'h4321_0000);
      bus(0, 4'h0, 32'h0);
      chk("lock_bad_key", 1, rdat[0]);
      bus(1, 4'h5, 32'h1234_0000);
      bus(0, 4'h0, 32'h0);
      chk("lock_good_key", 0, rdat[0]);
      $display("done lock");
      pol = 12'h5A5;
      bus(1, 4'h2, {20'h0, pol});
      bus(1, 4'h0, 32'h2);
      chk("save_busy", 1, busy);
      bus(1, 4'h2, 32'h0);
      wnv(200);
      bus(0, 4'h2, 32'h0);
      chk("pol_after_save", pol, rdat);
      bus(1, 4'h2, 32'h123);
      bus(1, 4'h0, 32'h4);
      wnv(200);
      bus(0, 4'h2, 32'h0);
      chk("pol_after_load", pol, rdat);
      rst_n <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(1);
      wnv(40000);
      bus(0, 4'h2, 32'h0);
      chk("pol_after_restart", pol, rdat);
      $display("done nonvolatile");
      end_of_test();
   end
endmodule : tb
